// *** tb/rbr_buf_mem.sv ***
// Host-side view of the receive buffer memory.
// Assumes one byte write per clock from the ring writer.
`timescale 1ns/1ps
module rbr_buf_mem
  import rbr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] addr,
  input  wire logic [7:0]        wdata
);
  // ==========================================================
  // Storage; unwritten bytes stay unknown so stray reads show
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  // Capture local receive writes for the host to read back
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule

// *** tb/rbr_rx_ring_bench.sv ***
// Self-checking bench for the receive filter and buffer ring.
// Assumes the register indices and header layout of rbr_pkg.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module rbr_rx_ring_bench;
  import rbr_pkg::*;
  logic              SYS_CLK, SYS_RST, REG_WR, REG_RD, RX_VALID, RX_LAST, RX_ERR;
  logic              RX_READY, MEM_WE;
  logic [4:0]        REG_ADDR;
  logic [7:0]        REG_WDATA, REG_RDATA, RX_DATA, MEM_WDATA;
  logic [MEM_AW-1:0] MEM_ADDR;
  logic [47:0]       ua, ma;
  int                n_errors, n_compared;
  logic              hold_seen;
  // ==========================================================
  // Design and host-side memory
  rbr_rx_ring u_rbr_rx_ring (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST), .RX_ERR(RX_ERR),
    .RX_READY(RX_READY), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA));
  rbr_buf_mem u_rbr_buf_mem (.clk(SYS_CLK), .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA));
  // ==========================================================
  // Tasks; all but the watchdog's finish_test entered 1 ns after a rising edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(posedge SYS_CLK);
    #1 REG_WR = 1'b0;
    @(posedge SYS_CLK);
    #1;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge SYS_CLK);
    #1 REG_RD = 1'b0;
    `CHK(REG_RDATA & m, e)
    @(posedge SYS_CLK);
    #1;
  endtask
  task automatic set_hash(input logic [63:0] v);
    for (int i = 0; i < 8; i++) wr(REG_HASH_BASE + 5'(i), v[8*i +: 8]);
  endtask
  // Payload byte i carries i so any placement slip shows
  task automatic send(input logic [47:0] da, input int n, input logic err);
    for (int i = 0; i < n; i++) begin
      RX_VALID = 1'b1;
      RX_DATA = (i < 6) ? da[8*i +: 8] : i[7:0];
      RX_LAST = (i == n - 1);
      RX_ERR = err;
      while (!RX_READY) begin @(posedge SYS_CLK); #1; end
      @(posedge SYS_CLK);
      #1;
    end
    hold_seen = !RX_READY;
    RX_VALID = 1'b0;
    RX_LAST = 1'b0;
    RX_ERR = 1'b0;
    repeat (8) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic good(input logic [7:0] p, nx, input int n, input logic [7:0] st);
    `CHK(hold_seen, 1'b1)
    `CHK(u_rbr_buf_mem.mem[{p[5:0], 8'h00}], st)
    `CHK(u_rbr_buf_mem.mem[{p[5:0], 8'h01}], nx)
    `CHK(u_rbr_buf_mem.mem[{p[5:0], 8'h02}], n[7:0])
    `CHK(u_rbr_buf_mem.mem[{p[5:0], 8'h03}], n[15:8])
    `CHK(u_rbr_buf_mem.mem[{p[5:0], 8'h0a}], 8'h06)
    rd_chk(REG_WRITE_PAGE, nx);
  endtask
  // Reflected CRC over the destination, bit 0 first
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h0);
    return c[31:26];
  endfunction
  task automatic finish_test();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog of 30000 cycles sized well above the roughly 1200 cycles used
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {REG_WR, REG_RD, RX_VALID, RX_LAST, RX_ERR, REG_ADDR, REG_WDATA, RX_DATA} = '0;
    n_errors = 0;
    n_compared = 0;
    SYS_RST = 1'b1;
    repeat (6) @(posedge SYS_CLK);
    #1 SYS_RST = 1'b0;
    rd_chk(REG_RING_FIRST, RST_PAGE);
    wr(5'h1f, 8'haa);
    rd_chk(5'h1f, 8'h00);
    wr(REG_RING_FIRST, 8'h01);
    wr(REG_RING_END, 8'h04);
    wr(REG_WRITE_PAGE, 8'h01);
    rd_chk(REG_RING_END, 8'h04);
    ua = 48'h554433221102;
    for (int i = 0; i < 6; i++) wr(REG_DEST_BASE + 5'(i), ua[8*i +: 8]);
    rd_chk(REG_DEST_BASE + 5'h5, 8'h55);
    send(ua, 8, 1'b0);
    good(8'h01, 8'h02, 8, 8'h01);
    for (int k = 0; k < 6; k++) begin
      send(ua ^ (48'h2 << (8 * k)), 8, 1'b0);
      rd_chk(REG_RX_STATUS, 8'h00, 8'h01);
    end
    send('1, 8, 1'b0);
    rd_chk(REG_RX_STATUS, 8'h00, 8'h01);
    wr(REG_RX_CFG, 8'h01);
    send(48'h7fffffffffff, 8, 1'b0);
    rd_chk(REG_RX_STATUS, 8'h00, 8'h01);
    send('1, 8, 1'b0);
    good(8'h02, 8'h03, 8, 8'h21);
    // Group path: every bit but the hashed one, then only that one
    ma = 48'h0000005e0001;
    wr(REG_RX_CFG, 8'h02);
    set_hash(~(64'h1 << hidx(ma)));
    send(ma, 8, 1'b0);
    rd_chk(REG_RX_STATUS, 8'h00, 8'h01);
    set_hash('1);
    send(48'h0000005e0000, 8, 1'b0);
    rd_chk(REG_RX_STATUS, 8'h00, 8'h01);
    set_hash(64'h1 << hidx(ma));
    send(ma, 8, 1'b0);
    good(8'h03, 8'h01, 8, 8'h21);
    wr(REG_RX_CFG, 8'h04);
    send(48'h0000000000aa, 8, 1'b0);
    good(8'h01, 8'h02, 8, 8'h01);
    // Long frame from the last page wraps to the first
    wr(REG_RX_CFG, 8'h00);
    wr(REG_WRITE_PAGE, 8'h03);
    send(ua, 260, 1'b0);
    good(8'h03, 8'h02, 260, 8'h01);
    `CHK(u_rbr_buf_mem.mem[{6'h01, 8'h00}], 8'hfc)
    send(ua, 8, 1'b1);
    rd_chk(REG_WRITE_PAGE, 8'h02);
    wr(REG_RX_CFG, 8'h08);
    send(ua, 8, 1'b1);
    good(8'h02, 8'h03, 8, 8'h02);
    wr(REG_RX_CFG, 8'h00);
    wr(REG_BOUNDARY, 8'h01);
    send(ua, 260, 1'b0);
    rd_chk(REG_RX_STATUS, 8'h02, 8'h03);
    rd_chk(REG_WRITE_PAGE, 8'h03);
    wr(REG_BOUNDARY, 8'h02);
    send(ua, 260, 1'b0);
    good(8'h03, 8'h02, 260, 8'h01);
    finish_test();
  end
endmodule

// *** verilog/rbr_addr_filter.sv ***
// Destination address classifier: unicast, hashed group and all-ones.
// Assumes start marks the first byte of a frame; bytes arrive in order.
`timescale 1ns/1ps
module rbr_addr_filter
  import rbr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  start,
  input  wire logic                  byte_valid,
  input  wire logic [7:0]            byte_data,
  input  wire logic [8*DEST_BYTES-1:0] dest_match_bytes,
  input  wire logic [8*HASH_BYTES-1:0] hash_filter_bytes,
  input  wire rbr_cfg_type           cfg,
  output rbr_match_type              match
);

  typedef struct packed {
    logic [47:0] da;
    logic [2:0]  cnt;
    logic [31:0] crc;
    logic [5:0]  hash;
    logic        done;
  } rbr_flt_type;

  rbr_flt_type s_reg;
  rbr_flt_type s_next;
  logic [2:0]  byte_pos;
  logic [31:0] crc_new;

  // CRC over one byte, least significant bit first as on the wire
  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
    end
    return c;
  endfunction

  // ==========================================================================
  // Capture the six destination bytes and run them through the CRC
  always_comb begin
    s_next   = s_reg;
    byte_pos = start ? 3'h0 : s_reg.cnt;
    crc_new  = crc_byte(start ? CRC_INIT : s_reg.crc, byte_data);
    if (byte_valid && (start || !s_reg.done)) begin
      s_next.crc                        = crc_new;
      s_next.da[{byte_pos, 3'b000} +: 8] = byte_data;
      s_next.cnt                        = 3'(byte_pos + 3'h1);
      s_next.done                       = (byte_pos == DA_LAST_BYTE);
      if (byte_pos == DA_LAST_BYTE) begin
        s_next.hash = crc_new[31:26];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Match results; the final decision is only meaningful once done is set
  always_comb begin
    match.done         = s_reg.done;
    match.unicast_hit  = s_reg.done && (s_reg.da == dest_match_bytes);
    match.group_hit    = s_reg.done && s_reg.da[0]
                         && hash_filter_bytes[s_reg.hash];
    match.all_ones_hit = s_reg.done && (&s_reg.da);
    match.final_accept = match.unicast_hit
                         || (match.group_hit && cfg.group_rx_en)
                         || (match.all_ones_hit && cfg.all_ones_rx_en)
                         || cfg.accept_any_en;
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  unicast_miss_a: assert property ((s_reg.done && s_reg.da != dest_match_bytes)
    |-> !match.unicast_hit) else $error("unicast hit on differing address");
  hash_latch_a: assert property ((byte_valid && !start && !s_reg.done && s_reg.cnt == 3'h5)
    |=> (s_reg.done && s_reg.hash == $past(crc_new[31:26])))
    else $error("hash index not latched after sixth byte");
  group_only_a: assert property (match.group_hit |-> (s_reg.da[0] && s_reg.done))
    else $error("group hit on individual address");
  all_ones_a: assert property ((s_reg.done && s_reg.da != {48{1'b1}})
    |-> !match.all_ones_hit) else $error("all-ones hit with a zero bit");
  accept_any_a: assert property (cfg.accept_any_en |-> match.final_accept)
    else $error("accept-any did not accept");

endmodule

// *** verilog/rbr_page_link.sv ***
// Next-page calculation for the receive buffer ring.
// Assumes page registers are stable while a frame is being stored.
`timescale 1ns/1ps
module rbr_page_link
  import rbr_pkg::*;
(
  input  wire logic [7:0] page,
  input  wire logic [7:0] ring_first_page,
  input  wire logic [7:0] ring_end_page,
  input  wire logic [7:0] boundary,
  output logic      [7:0] next_page,
  output logic            hits_boundary
);

  // ==========================================================================
  // Link: always the next contiguous page, wrapping at the end page
  always_comb begin
    next_page = 8'(page + 8'h01);
    if (next_page == ring_end_page) begin
      next_page = ring_first_page;
    end
    hits_boundary = (next_page == boundary);
  end

endmodule

// *** verilog/rbr_pkg.sv ***
// Package for the receive address filter and receive buffer ring.
// Assumes one 100 MHz clock and a byte-wide MAC receive stream.
// Summary of operation
// - Compare six destination bytes to six match bytes; any difference is unicast miss.
// - Match byte n holds destination bits 8n+7..8n; bit 0 arrives first.
// - Destination runs through 32-bit CRC; six top bits latched as hash index.
// - Hash index selects one of 64 filter bits; set bit gives group match.
// - Eight 8-bit filter registers hold the 64 bits, register n bits 8n+7..8n.
// - First received bit one marks multicast; only those use the hash filter.
// - All-ones match only when all 48 destination bits are one.
// - Final accept merges match results with the receive enables.
// - Reception is local write; host removes frames by remote read.
// - Ring is built of contiguous 256-byte pages.
// - Two 8-bit page registers bound the ring in 16K-byte memory.
// - Reaching ring end page reloads the write address with ring first page.
// - Write-page pointer marks frame start; used for status and error restore.
// - Reaching the boundary page aborts the current reception.
// - Frame storage starts at write-page pointer, skipping four status bytes.
// - On linking, wrap at ring end, abort at boundary, never skip pages.
// - Good frame: write status, next page, byte count, then advance pointer.
// - Rejected frame pages are reclaimed unless error frames are accepted.
package rbr_pkg;

  // ==========================================================================
  // Register indices on the local register port
  localparam logic [4:0] REG_RING_FIRST = 5'h01;
  localparam logic [4:0] REG_RING_END   = 5'h02;
  localparam logic [4:0] REG_BOUNDARY   = 5'h03;
  localparam logic [4:0] REG_RX_CFG     = 5'h04;
  localparam logic [4:0] REG_WRITE_PAGE = 5'h05;
  localparam logic [4:0] REG_RX_STATUS  = 5'h06;
  localparam logic [4:0] REG_DEST_BASE  = 5'h08;
  localparam logic [4:0] REG_HASH_BASE  = 5'h10;
  localparam int         DEST_BYTES     = 6;
  localparam int         HASH_BYTES     = 8;

  // ==========================================================================
  // Field positions and reset values
  localparam int         CFG_ALL_ONES   = 0;
  localparam int         CFG_GROUP      = 1;
  localparam int         CFG_ANY        = 2;
  localparam int         CFG_ERR        = 3;
  localparam int         STS_ACCEPT     = 0;
  localparam int         STS_ABORT      = 1;
  localparam int         STS_BUSY       = 2;
  localparam int         HDR_OK         = 0;
  localparam int         HDR_ERR        = 1;
  localparam int         HDR_GROUP      = 5;
  localparam logic [7:0] RST_PAGE       = 8'h00;
  localparam logic [7:0] RST_BYTE       = 8'h00;

  // ==========================================================================
  // Ring and CRC constants
  localparam logic [7:0]  HDR_BYTES     = 8'h04;
  localparam logic [7:0]  PAGE_LAST_OFF = 8'hff;
  localparam logic [2:0]  DA_LAST_BYTE  = 3'h5;
  localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam int          MEM_AW        = 14;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic accept_err_en;
    logic accept_any_en;
    logic group_rx_en;
    logic all_ones_rx_en;
  } rbr_cfg_type;

  typedef struct packed {
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        wdata;
  } rbr_mem_type;

  typedef struct packed {
    logic done;
    logic unicast_hit;
    logic group_hit;
    logic all_ones_hit;
    logic final_accept;
  } rbr_match_type;

endpackage

// *** verilog/rbr_rx_ring.sv ***
// Receive path top: register file, address filter and buffer ring writer.
// Assumes the receive stream may be held off by RX_READY and that the
// buffer memory takes one byte write per clock.
`timescale 1ns/1ps
module rbr_rx_ring
  import rbr_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [4:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  output logic      [7:0]        REG_RDATA,
  input  wire logic              RX_VALID,
  input  wire logic [7:0]        RX_DATA,
  input  wire logic              RX_LAST,
  input  wire logic              RX_ERR,
  output logic                   RX_READY,
  output logic                   MEM_WE,
  output logic      [MEM_AW-1:0] MEM_ADDR,
  output logic      [7:0]        MEM_WDATA
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RECV = 4'b0010,
    ST_HDR  = 4'b0100,
    ST_DROP = 4'b1000
  } rbr_fsm_type;

  typedef struct packed {
    rbr_fsm_type         fsm;
    logic [7:0]          ring_first_page;
    logic [7:0]          ring_end_page;
    logic [7:0]          boundary;
    logic [7:0]          write_page_ptr;
    rbr_cfg_type         cfg;
    logic [47:0]         dest_match_bytes;
    logic [63:0]         hash_filter_bytes;
    logic [7:0]          page;
    logic [7:0]          off;
    logic [15:0]         byte_cnt;
    logic [7:0]          next_free;
    logic [1:0]          hdr_idx;
    logic [7:0]          hdr_status;
    logic                abort_seen;
    logic                last_accept;
    rbr_mem_type         mem;
    logic [7:0]          rdata;
  } rbr_state_type;

  rbr_state_type s_reg;
  rbr_state_type s_next;
  rbr_match_type match;
  logic          take;
  logic          filt_start;
  logic [7:0]    cur_page;
  logic [7:0]    cur_off;
  logic [15:0]   cur_cnt;
  logic [7:0]    link_next;
  logic          link_hit;
  logic          aborting;
  logic          frame_ok;

  // Buffer memory byte address from page and offset
  function automatic logic [MEM_AW-1:0] mem_addr(input logic [7:0] page, input logic [7:0] off);
    return MEM_AW'({page, off});
  endfunction

  // Register read decode
  function automatic logic [7:0] read_mux(input rbr_state_type s, input logic [4:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      REG_RING_FIRST: d = s.ring_first_page;
      REG_RING_END:   d = s.ring_end_page;
      REG_BOUNDARY:   d = s.boundary;
      REG_RX_CFG:     d = {4'h0, s.cfg};
      REG_WRITE_PAGE: d = s.write_page_ptr;
      REG_RX_STATUS: begin
        d[STS_ACCEPT] = s.last_accept;
        d[STS_ABORT]  = s.abort_seen;
        d[STS_BUSY]   = (s.fsm != ST_IDLE);
      end
      default: begin
        if (a >= REG_DEST_BASE && a < 5'(REG_DEST_BASE + DEST_BYTES)) begin
          d = s.dest_match_bytes[{a[2:0], 3'b000} +: 8];
        end else if (a >= REG_HASH_BASE && a < 5'(REG_HASH_BASE + HASH_BYTES)) begin
          d = s.hash_filter_bytes[{a[2:0], 3'b000} +: 8];
        end
      end
    endcase
    return d;
  endfunction

  // ==========================================================================
  // Submodules
  rbr_addr_filter u_filter (
    .clk               (SYS_CLK),
    .rst               (SYS_RST),
    .start             (filt_start),
    .byte_valid        (take),
    .byte_data         (RX_DATA),
    .dest_match_bytes  (s_reg.dest_match_bytes),
    .hash_filter_bytes (s_reg.hash_filter_bytes),
    .cfg               (s_reg.cfg),
    .match             (match)
  );

  rbr_page_link u_link (
    .page            (cur_page),
    .ring_first_page (s_reg.ring_first_page),
    .ring_end_page   (s_reg.ring_end_page),
    .boundary        (s_reg.boundary),
    .next_page       (link_next),
    .hits_boundary   (link_hit)
  );

  // ==========================================================================
  // Stream handshake; held off only while the header is written back
  assign RX_READY   = (s_reg.fsm != ST_HDR);
  assign take       = RX_VALID && (s_reg.fsm == ST_IDLE || s_reg.fsm == ST_RECV);
  assign filt_start = RX_VALID && (s_reg.fsm == ST_IDLE);

  // A new frame starts at the write-page pointer past the status bytes
  always_comb begin
    cur_page = (s_reg.fsm == ST_IDLE) ? s_reg.write_page_ptr : s_reg.page;
    cur_off  = (s_reg.fsm == ST_IDLE) ? HDR_BYTES : s_reg.off;
    cur_cnt  = (s_reg.fsm == ST_IDLE) ? 16'h0000 : s_reg.byte_cnt;
    aborting = (cur_off == PAGE_LAST_OFF) && link_hit;
    // Short frames never complete the filter, so they fall out as runts;
    // in idle the filter still shows the previous frame, so it is not trusted
    frame_ok = match.done && match.final_accept && !aborting && (s_reg.fsm == ST_RECV)
               && (!RX_ERR || s_reg.cfg.accept_err_en);
  end

  // ==========================================================================
  // Next state: registers, frame storage and header write-back
  always_comb begin
    s_next        = s_reg;
    s_next.mem.we = 1'b0;

    // Local register port writes
    if (REG_WR) begin
      case (REG_ADDR)
        REG_RING_FIRST: s_next.ring_first_page = REG_WDATA;
        REG_RING_END:   s_next.ring_end_page   = REG_WDATA;
        REG_BOUNDARY:   s_next.boundary        = REG_WDATA;
        REG_RX_CFG:     s_next.cfg             = rbr_cfg_type'(REG_WDATA[3:0]);
        REG_WRITE_PAGE: s_next.write_page_ptr  = REG_WDATA;
        REG_RX_STATUS:  s_next.abort_seen      = 1'b0;
        default: begin
          if (REG_ADDR >= REG_DEST_BASE && REG_ADDR < 5'(REG_DEST_BASE + DEST_BYTES)) begin
            s_next.dest_match_bytes[{REG_ADDR[2:0], 3'b000} +: 8] = REG_WDATA;
          end else if (REG_ADDR >= REG_HASH_BASE
                       && REG_ADDR < 5'(REG_HASH_BASE + HASH_BYTES)) begin
            s_next.hash_filter_bytes[{REG_ADDR[2:0], 3'b000} +: 8] = REG_WDATA;
          end
        end
      endcase
    end
    if (REG_RD) begin
      s_next.rdata = read_mux(s_reg, REG_ADDR);
    end

    case (s_reg.fsm)
      ST_IDLE, ST_RECV: begin
        if (take) begin
          // Local DMA write of one received byte, CRC included
          s_next.mem.we    = 1'b1;
          s_next.mem.addr  = mem_addr(cur_page, cur_off);
          s_next.mem.wdata = RX_DATA;
          s_next.byte_cnt  = 16'(cur_cnt + 16'h0001);
          s_next.page      = cur_page;
          s_next.off       = 8'(cur_off + 8'h01);
          s_next.fsm       = ST_RECV;
          if (cur_off == PAGE_LAST_OFF) begin
            // Page full: link forward, or give up rather than overrun unread data
            if (link_hit) begin
              s_next.fsm        = ST_DROP;
              s_next.abort_seen = 1'b1;
              // An aborted frame is a rejected one as far as status goes
              s_next.last_accept = 1'b0;
            end else begin
              s_next.page = link_next;
            end
          end
          if (RX_LAST) begin
            s_next.last_accept = frame_ok;
            if (frame_ok) begin
              s_next.fsm                  = ST_HDR;
              s_next.hdr_idx              = 2'h0;
              s_next.next_free            = link_next;
              s_next.hdr_status           = 8'h00;
              s_next.hdr_status[HDR_OK]    = !RX_ERR;
              s_next.hdr_status[HDR_ERR]   = RX_ERR;
              s_next.hdr_status[HDR_GROUP] = match.group_hit || match.all_ones_hit;
            end else begin
              // Pointer untouched, so every page of this frame is free again
              s_next.fsm = ST_IDLE;
            end
          end
        end
      end
      ST_HDR: begin
        // Status, next page, count low, count high into the frame's first page
        s_next.mem.we   = 1'b1;
        s_next.mem.addr = mem_addr(s_reg.write_page_ptr, {6'h00, s_reg.hdr_idx});
        case (s_reg.hdr_idx)
          2'h0:    s_next.mem.wdata = s_reg.hdr_status;
          2'h1:    s_next.mem.wdata = s_reg.next_free;
          2'h2:    s_next.mem.wdata = s_reg.byte_cnt[7:0];
          default: s_next.mem.wdata = s_reg.byte_cnt[15:8];
        endcase
        s_next.hdr_idx = 2'(s_reg.hdr_idx + 2'h1);
        if (s_reg.hdr_idx == 2'h3) begin
          s_next.write_page_ptr = s_reg.next_free;
          s_next.fsm            = ST_IDLE;
        end
      end
      ST_DROP: begin
        // Swallow the rest of an aborted frame; its pages are reclaimed
        if (RX_VALID && RX_LAST) begin
          s_next.fsm = ST_IDLE;
        end
      end
      default: begin
        s_next.fsm = ST_IDLE;
      end
    endcase

    // An abort in the same cycle as a status write still sticks
    if (take && aborting) begin
      s_next.abort_seen = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_reg                   <= '0;
      s_reg.fsm               <= ST_IDLE;
      s_reg.ring_first_page   <= RST_PAGE;
      s_reg.ring_end_page     <= RST_PAGE;
      s_reg.boundary          <= RST_PAGE;
      s_reg.write_page_ptr    <= RST_PAGE;
      s_reg.rdata             <= RST_BYTE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA = s_reg.rdata;
  assign MEM_WE    = s_reg.mem.we;
  assign MEM_ADDR  = s_reg.mem.addr;
  assign MEM_WDATA = s_reg.mem.wdata;

  // ==========================================================================
  // Checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  sequence hdr_writes_s;
    (MEM_WE && MEM_ADDR[7:0] == 8'h00) ##1 (MEM_WE && MEM_ADDR[7:0] == 8'h01)
    ##1 (MEM_WE && MEM_ADDR[7:0] == 8'h02) ##1 (MEM_WE && MEM_ADDR[7:0] == 8'h03);
  endsequence

  // Stream held off for the four header cycles, one cycle ahead of the header bytes on the memory port
  sequence hold_off_s;
    !RX_READY [*4] ##1 RX_READY;
  endsequence

  frame_start_a: assert property ((s_reg.fsm == ST_IDLE && RX_VALID)
    |=> (MEM_WE && MEM_ADDR == mem_addr($past(s_reg.write_page_ptr), HDR_BYTES)))
    else $error("frame not started past status bytes");
  ring_wrap_a: assert property ((take && !RX_LAST && cur_off == PAGE_LAST_OFF && !link_hit
    && 8'(cur_page + 8'h01) == s_reg.ring_end_page)
    |=> (s_reg.page == s_reg.ring_first_page)) else $error("ring did not wrap");
  boundary_abort_a: assert property ((take && !RX_LAST && aborting)
    |=> (s_reg.fsm == ST_DROP && s_reg.abort_seen)) else $error("boundary not honoured");
  reject_keep_a: assert property ((take && RX_LAST && !frame_ok)
    |=> (s_reg.fsm == ST_IDLE && $stable(s_reg.write_page_ptr)))
    else $error("rejected frame kept pages");
  header_seq_a: assert property ((take && RX_LAST && frame_ok)
    |=> ##1 hdr_writes_s ##0 (s_reg.write_page_ptr == s_reg.next_free))
    else $error("header write-back sequence wrong");

  // Handshake and pointer checks
  hdr_hold_a: assert property ((take && RX_LAST && frame_ok) |=> hold_off_s)
    else $error("stream not held off for header write-back");
  drop_quiet_a: assert property ((s_reg.fsm == ST_DROP) |=> !MEM_WE)
    else $error("aborted frame still written");
  wpp_hold_a: assert property ((s_reg.fsm != ST_HDR
    && !(REG_WR && REG_ADDR == REG_WRITE_PAGE)) |=> $stable(s_reg.write_page_ptr))
    else $error("write-page pointer moved outside header");

endmodule
